//--- hdl/stpwm_core.sv
// standard timer core: pwm output, single pulse output and input capture
//
// Overview of operation
// R1: swap clear: period is period value x256 (zero means 65536), duty is compare-a.
// R2: swap set: compare-a sets period, duty is period value x256 (zero means 65536).
// R3: duty at or above period keeps the output active the whole period.
// R4: pwm counter and compare keep running while output is forced to a level.
// R5: pwm ignores clear select; the period comparator (compare-a when swap is set) clears the counter, starting a period.
// R6: software selects single pulse with mode 10 and pin function 11.
// R7: counter-on rise starts counter and pulse; external pin edge sets counter-on.
// R8: pulse ends when counter-on clears; compare-a match clears counter-on itself.
// R9: single pulse compare-a match raises the compare-a interrupt request.
// R10: single pulse counter clears only on counter-on rise; period, clear, swap ignored.
// R11: software keeps pin function at 11 throughout single pulse mode.
// R12: capture mode is code 01; counter starts on counter-on rising edge.
// R13: capture pin function chooses rising, falling or both capture edges.
// R14: each selected capture edge copies the counter into compare-a and raises interrupt.
// R15: capture counter runs regardless of input until counter-on falls.
// R16: capture period match clears the counter and raises the period interrupt.
// R17: capture with period value zero runs the counter to full count then wraps.
// R18: capture pin function 11 disables capture while the counter keeps running.
// R19: capture mode has no output; level, polarity, clear and swap bits unused.
// R20: counter is 16 bits; period value compares with its upper eight bits.
// R21: pwm initial-level bit picks active level, polarity bit inverts the output.
// R22: counter advances once per enabled timer tick while counter-on, else holds.
`timescale 1ns/1ps
`default_nettype none

module stpwm_core
  import stpwm_pkg::*;
#(
  parameter int unsigned CNT_W = STPWM_CNT_W
) (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   tick_i,
  input  wire logic                   counter_on_set_i,
  input  wire logic                   counter_on_clr_i,
  input  wire logic                   mode_select_hi_i,
  input  wire logic                   mode_select_lo_i,
  input  wire logic                   pin_function_hi_i,
  input  wire logic                   pin_function_lo_i,
  input  wire logic                   output_initial_level_i,
  input  wire logic                   output_polarity_i,
  input  wire logic                   counter_clear_select_i,
  input  wire logic                   period_duty_swap_i,
  input  wire logic [STPWM_PER_W-1:0] period_compare_value_i,
  input  wire logic                   compare_a_wr_i,
  input  wire logic [CNT_W-1:0]       compare_a_wdata_i,
  input  wire logic                   ext_clock_trigger_pin_i,
  input  wire logic                   capture_input_pin_i,
  input  wire logic                   compare_a_flag_clr_i,
  input  wire logic                   period_compare_flag_clr_i,
  output logic                        counter_on_o,
  output logic [CNT_W-1:0]            counter_o,
  output logic [CNT_W-1:0]            compare_a_value_o,
  output logic                        compare_a_flag_o,
  output logic                        period_compare_flag_o,
  output logic                        timer_out_o
);

  if (CNT_W != 16) begin : g_chk
    $error("stpwm_core: counter width must be 16");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic             on_q,   on_d;
  logic [CNT_W-1:0] cnt_q,  cnt_d;
  logic [CNT_W-1:0] compare_a_value_q, compare_a_value_d;
  logic             af_q,   af_d;
  logic             pf_q,   pf_d;
  logic             out_q,  out_d;
  logic             on_prev_q;
  logic             pin_prev_q;
  logic             trig_prev_q;
  logic             act_q,  act_d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [1:0] mode_w = {mode_select_hi_i, mode_select_lo_i};
  wire logic [1:0] pf_w   = {pin_function_hi_i, pin_function_lo_i};
  wire logic is_pwm_w   = (mode_w == STPWM_MODE_PWM) && (pf_w != STPWM_PF_PULSE);
  wire logic is_pulse_w = (mode_w == STPWM_MODE_PWM) && (pf_w == STPWM_PF_PULSE); // R6 R11
  wire logic is_cap_w   = (mode_w == STPWM_MODE_CAP); // R12

  wire logic on_rise_w  = on_q && !on_prev_q;
  wire logic cnt_step_w = on_q && tick_i; // R22

  // period value in the counter's upper byte; zero selects full 16-bit span
  wire logic [STPWM_PER_W-1:0] cnt_hi_w = cnt_q[CNT_W-1 -: STPWM_PER_W]; // R20
  wire logic per_zero_w  = (period_compare_value_i == 8'h00);
  wire logic cnt_max_w   = (cnt_q == {CNT_W{1'b1}});
  // p-match fires on the last count of the span so the period is exactly n x 256
  wire logic p_last_w    = per_zero_w ? cnt_max_w
                         : ((cnt_hi_w == period_compare_value_i - 8'h01)
                            && (cnt_q[STPWM_PER_LSB-1:0] == 8'hff)); // R1 R17 R20
  wire logic p_match_w   = cnt_step_w && p_last_w;
  wire logic a_last_w    = (cnt_q + 16'h0001 == compare_a_value_q);
  wire logic a_match_w   = cnt_step_w && a_last_w;

  // pwm: roles follow the swap bit
  wire logic [16:0] per_span_w = per_zero_w ? 17'h10000
                               : {1'b0, period_compare_value_i, 8'h00};
  wire logic [16:0] period_w = period_duty_swap_i ? {1'b0, compare_a_value_q} : per_span_w; // R1 R2
  wire logic [16:0] duty_w   = period_duty_swap_i ? per_span_w : {1'b0, compare_a_value_q}; // R1 R2
  wire logic pwm_wrap_w = period_duty_swap_i ? a_match_w : p_match_w; // R5
  wire logic pwm_act_w  = (duty_w >= period_w) || ({1'b0, cnt_q} < duty_w); // R3

  // capture edge selection
  wire logic cap_rise_w = capture_input_pin_i && !pin_prev_q;
  wire logic cap_fall_w = !capture_input_pin_i && pin_prev_q;
  wire logic cap_hit_w  = is_cap_w && on_q && (
                            (pf_w == STPWM_CAP_RISE && cap_rise_w) ||
                            (pf_w == STPWM_CAP_FALL && cap_fall_w) ||
                            (pf_w == STPWM_CAP_BOTH && (cap_rise_w || cap_fall_w))); // R13 R18
  wire logic trig_edge_w = ext_clock_trigger_pin_i && !trig_prev_q;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    on_d   = on_q;
    cnt_d  = cnt_q;
    compare_a_value_d = compare_a_value_q;
    af_d   = af_q && !compare_a_flag_clr_i;
    pf_d   = pf_q && !period_compare_flag_clr_i;
    act_d  = act_q;
    out_d  = out_q;

    if (counter_on_set_i || (is_pulse_w && trig_edge_w)) begin
      on_d = 1'b1; // R7
    end else if (counter_on_clr_i) begin
      on_d = 1'b0; // R8 R15
    end

    if (on_rise_w) begin
      cnt_d = STPWM_CNT_RST; // R10 R12
    end else if (cnt_step_w) begin
      cnt_d = cnt_q + 16'h0001; // R22 R4
      if (is_pwm_w && pwm_wrap_w) begin
        cnt_d = STPWM_CNT_RST; // R5
      end
      if (is_cap_w && p_match_w) begin
        cnt_d = STPWM_CNT_RST; // R16 R17
      end
    end

    if (is_pwm_w) begin
      if (a_match_w) begin
        af_d = 1'b1;
      end
      if (p_match_w) begin
        pf_d = 1'b1;
      end
      act_d = pwm_act_w; // R4
    end else if (is_pulse_w) begin
      if (a_match_w) begin
        on_d = 1'b0; // R8
        af_d = 1'b1; // R9
      end
      act_d = on_d;
    end else if (is_cap_w) begin
      if (p_match_w) begin
        pf_d = 1'b1; // R16
      end
      if (cap_hit_w) begin
        af_d = 1'b1; // R14
      end
      act_d = 1'b0;
    end

    // software writes lose to a capture in the same cycle
    if (compare_a_wr_i) begin
      compare_a_value_d = compare_a_wdata_i;
    end
    if (cap_hit_w) begin
      compare_a_value_d = cnt_q; // R14
    end

    // output pin level
    if (is_pwm_w || is_pulse_w) begin
      unique case (pf_w)
        STPWM_PF_INACT: out_d = !output_initial_level_i ^ output_polarity_i; // R4
        STPWM_PF_ACT:   out_d = output_initial_level_i ^ output_polarity_i;  // R4
        default:        out_d = (act_d ? output_initial_level_i
                                       : !output_initial_level_i) ^ output_polarity_i; // R21
      endcase
    end else if (is_cap_w) begin
      out_d = 1'b0; // R19
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      on_q        <= 1'b0;
      on_prev_q   <= 1'b0;
      cnt_q       <= STPWM_CNT_RST;
      compare_a_value_q      <= STPWM_COMPARE_A_VALUE_RST;
      af_q        <= 1'b0;
      pf_q        <= 1'b0;
      act_q       <= 1'b0;
      out_q       <= 1'b0;
      pin_prev_q  <= 1'b0;
      trig_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      on_q        <= on_d;
      on_prev_q   <= on_q;
      cnt_q       <= cnt_d;
      compare_a_value_q      <= compare_a_value_d;
      af_q        <= af_d;
      pf_q        <= pf_d;
      act_q       <= act_d;
      out_q       <= out_d;
      pin_prev_q  <= capture_input_pin_i;
      trig_prev_q <= ext_clock_trigger_pin_i;
    end
  end

  assign counter_on_o          = on_q;
  assign counter_o             = cnt_q;
  assign compare_a_value_o     = compare_a_value_q;
  assign compare_a_flag_o      = af_q;
  assign period_compare_flag_o = pf_q;
  assign timer_out_o           = out_q;

endmodule

`default_nettype wire

//--- hdl/stpwm_pkg.sv
// package: constants for the standard timer pwm/pulse/capture block
package stpwm_pkg;

  localparam int unsigned STPWM_CNT_W   = 16;
  localparam int unsigned STPWM_PER_W   = 8;
  localparam int unsigned STPWM_PER_LSB = 8;

  // mode field codes
  localparam logic [1:0] STPWM_MODE_CMP  = 2'h0;
  localparam logic [1:0] STPWM_MODE_CAP  = 2'h1;
  localparam logic [1:0] STPWM_MODE_PWM  = 2'h2;
  localparam logic [1:0] STPWM_MODE_TMR  = 2'h3;

  // pin function codes, pwm / single pulse
  localparam logic [1:0] STPWM_PF_INACT  = 2'h0;
  localparam logic [1:0] STPWM_PF_ACT    = 2'h1;
  localparam logic [1:0] STPWM_PF_PWM    = 2'h2;
  localparam logic [1:0] STPWM_PF_PULSE  = 2'h3;

  // pin function codes, capture
  localparam logic [1:0] STPWM_CAP_RISE  = 2'h0;
  localparam logic [1:0] STPWM_CAP_FALL  = 2'h1;
  localparam logic [1:0] STPWM_CAP_BOTH  = 2'h2;
  localparam logic [1:0] STPWM_CAP_OFF   = 2'h3;

  // reset values
  localparam logic [15:0] STPWM_CNT_RST  = 16'h0000;
  localparam logic [15:0] STPWM_COMPARE_A_VALUE_RST = 16'h0000;

endpackage

//--- test/stpwm_core_tb.sv
// testbench: directed checks of the standard timer core
`timescale 1ns/1ps
`default_nettype none
module stpwm_core_tb;
  import stpwm_pkg::*;
  logic clk_i, nrst_i, en, tick, set, clr, oil, pol, ccs, swp, awr, fca, fcp, crq, trq;
  logic [1:0] md, pf;
  logic [7:0] pcv;
  logic [15:0] awd;
  logic [3:0] dly;
  wire logic cpin, tpin, on, fa, fp, tout;
  wire logic [15:0] cnt, compare_a_value;
  int failures, n_tests;
  stpwm_core stpwm_core_i (.clk_i(clk_i), .nrst_i(nrst_i), .clk_en_i(en), .tick_i(tick), .counter_on_set_i(set),
    .counter_on_clr_i(clr), .mode_select_hi_i(md[1]), .mode_select_lo_i(md[0]), .pin_function_hi_i(pf[1]),
    .pin_function_lo_i(pf[0]), .output_initial_level_i(oil), .output_polarity_i(pol), .counter_clear_select_i(ccs),
    .period_duty_swap_i(swp), .period_compare_value_i(pcv), .compare_a_wr_i(awr), .compare_a_wdata_i(awd),
    .ext_clock_trigger_pin_i(tpin), .capture_input_pin_i(cpin), .compare_a_flag_clr_i(fca),
    .period_compare_flag_clr_i(fcp), .counter_on_o(on), .counter_o(cnt), .compare_a_value_o(compare_a_value),
    .compare_a_flag_o(fa), .period_compare_flag_o(fp), .timer_out_o(tout));
  stpwm_pins stpwm_pins_i (.clk_i(clk_i), .cap_req_i(crq), .trg_req_i(trq), .dly_i(dly), .cap_o(cpin), .trg_o(tpin));
  task automatic cyc(input int n); repeat (n) @(negedge clk_i); endtask
  task automatic cmp(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic stp; clr = 1; cyc(1); clr = 0; fca = 1; fcp = 1; cyc(1); fca = 0; fcp = 0; endtask
  task automatic go; set = 1; cyc(1); set = 0; cyc(2); endtask
  task automatic wra(input logic [15:0] v); awd = v; awr = 1; cyc(1); awr = 0; endtask
  task automatic t_reset; cmp({on, fa, fp, tout}, 4'h0); cmp(cnt | compare_a_value, 16'h0000); endtask
  task automatic t_pwm(input logic s, c, input logic [7:0] p, input logic [15:0] a, input int per, dut);
    int n;
    n = 0;
    stp; md = STPWM_MODE_PWM; pf = STPWM_PF_PWM; swp = s; ccs = c; pcv = p; oil = 1; pol = 0; wra(a); go; cyc(per);
    repeat (per) begin cyc(1); n += tout; end
    cmp(n[15:0], dut[15:0]);
    cmp(s ? fa : fp, 1'b1);
  endtask
  task automatic t_forced;
    logic [15:0] c;
    for (int i = 0; i < 8; i++) begin
      stp; {oil, pol, pf} = {i[2:1], 1'b0, i[0]}; go;
      cmp(tout, !(oil ^ pf[0]) ^ pol);
      c = cnt; cyc(4); cmp(cnt - c, 16'h0004);
    end
  endtask
  task automatic t_pulse(input logic ext);
    stp; pf = STPWM_PF_PULSE; oil = 1; pol = 0; dly = 4'h3; wra(16'h0014);
    if (ext) trq = 1; else set = 1;
    cyc(1); set = 0;
    for (int i = 0; i < 9 && on !== 1'b1; i++) cyc(1);
    cyc(1); cmp(tout, 1'b1);
    for (int i = 0; i < 40 && on !== 1'b0; i++) cyc(1);
    cyc(2); cmp({on, fa, tout}, 3'b010);
    trq = 0; cyc(5);
  endtask
  task automatic t_cap;
    logic [15:0] c;
    logic [3:0] er = 4'b0101, ef = 4'b0110;
    stp; md = STPWM_MODE_CAP; pcv = 8'h00; dly = 4'h0; go;
    cmp(tout, 1'b0);
    for (int p = 0; p < 4; p++) begin
      pf = p[1:0]; fca = 1; cyc(1); fca = 0; crq = 1; cyc(3); cmp(fa, er[p]);
      fca = 1; cyc(1); fca = 0; crq = 0; cyc(3); cmp(fa, ef[p]);
    end
    cyc(300); cmp(cnt > 16'h00ff && !fp, 1'b1);
    stp; pcv = 8'h01; go; cyc(300); cmp(cnt < 16'h0100 && fp, 1'b1);
    c = cnt; en = 0; cyc(3); en = 1; tick = 0; cyc(3); tick = 1; cmp(cnt, c);
    stp; c = cnt; cyc(5); cmp(cnt, c);
  endtask
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {nrst_i, en, tick, set, clr, oil, pol, ccs, swp, awr, fca, fcp, crq, trq} = '0;
    {md, pf, pcv, awd, dly} = '0;
    failures = 0; n_tests = 0;
    cyc(5); nrst_i = 1; en = 1; tick = 1;
    t_reset;
    t_pwm(0, 1, 8'h01, 16'h0040, 256, 64);
    t_pwm(0, 0, 8'h01, 16'h012c, 256, 256);
    t_pwm(1, 0, 8'h02, 16'h0258, 600, 512);
    t_forced;
    t_pulse(0);
    t_pulse(1);
    t_cap;
    give_verdict;
  end
  // about six and a half times the expected run length
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
endmodule
bind stpwm_core stpwm_properties #(.CNT_W(CNT_W)) stpwm_properties_i (.*);
`default_nettype wire

//--- test/stpwm_pins.sv
// partner: outside drivers of the capture and trigger pins
`timescale 1ns/1ps
`default_nettype none
module stpwm_pins (
  input wire logic       clk_i, cap_req_i, trg_req_i,
  input wire logic [3:0] dly_i,
  output logic           cap_o, trg_o
);
  logic [3:0] wait_q;
  initial {cap_o, trg_o, wait_q} = '0;
  // a slow source follows a request only after dly_i cycles
  always @(negedge clk_i) begin
    if ({cap_o, trg_o} == {cap_req_i, trg_req_i} || wait_q == dly_i) wait_q <= 4'h0;
    else wait_q <= wait_q + 4'h1;
    if (wait_q == dly_i) {cap_o, trg_o} <= {cap_req_i, trg_req_i};
  end
endmodule
`default_nettype wire

//--- test/stpwm_properties.sv
// checker: port relations of the standard timer core
`timescale 1ns/1ps
`default_nettype none
module stpwm_properties
  import stpwm_pkg::*;
#(parameter int unsigned CNT_W = STPWM_CNT_W) (
  input wire logic clk_i, nrst_i, clk_en_i, tick_i, mode_select_hi_i, mode_select_lo_i, compare_a_wr_i,
  input wire logic pin_function_hi_i, pin_function_lo_i, output_initial_level_i, output_polarity_i,
  input wire logic [STPWM_PER_W-1:0] period_compare_value_i,
  input wire logic capture_input_pin_i, counter_on_o, compare_a_flag_o, period_compare_flag_o, timer_out_o,
  input wire logic [CNT_W-1:0] counter_o, compare_a_value_o
);
  logic cap_q;
  wire logic [1:0] md = {mode_select_hi_i, mode_select_lo_i};
  wire logic [1:0] pf = {pin_function_hi_i, pin_function_lo_i};
  wire logic [CNT_W-1:0] pend = {period_compare_value_i, 8'h00} - 16'h0001;
  wire logic pin = capture_input_pin_i;
  wire logic cap_ev = md == STPWM_MODE_CAP && counter_on_o && clk_en_i && (pf == STPWM_CAP_BOTH ? pin != cap_q :
    pf == STPWM_CAP_RISE ? pin && !cap_q : pf == STPWM_CAP_FALL && !pin && cap_q);
  wire logic run = counter_on_o && tick_i && clk_en_i;
  // frozen by clk_en_i like the core's own edge detector
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) cap_q <= 1'b0;
    else if (clk_en_i) cap_q <= pin;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_start; $rose(counter_on_o) && clk_en_i; endsequence
  sequence s_am; md == STPWM_MODE_PWM && pf == STPWM_PF_PULSE && run && $past(counter_on_o) &&
    counter_o + 16'h0001 == compare_a_value_o; endsequence
  sequence s_frc; md == STPWM_MODE_PWM && !pf[1] && clk_en_i; endsequence
  property p_hold; clk_en_i && !counter_on_o |=> $stable(counter_o); endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved");
  property p_start; s_start |=> counter_o == '0; endproperty
  a_start: assert property (p_start) else $error("no clear at start");
  property p_am; s_am |=> !counter_on_o && compare_a_flag_o; endproperty
  a_am: assert property (p_am) else $error("pulse not ended");
  property p_cap; cap_ev |=> compare_a_value_o == $past(counter_o) && compare_a_flag_o; endproperty
  a_cap: assert property (p_cap) else $error("capture missed");
  property p_nocap; !cap_ev && !compare_a_wr_i |=> $stable(compare_a_value_o); endproperty
  a_nocap: assert property (p_nocap) else $error("stray capture");
  property p_per; md == STPWM_MODE_CAP && run && $past(counter_on_o) && counter_o == pend
    |=> counter_o == '0 && period_compare_flag_o; endproperty
  a_per: assert property (p_per) else $error("period match missed");
  property p_run; md == STPWM_MODE_CAP && run && $past(counter_on_o) && counter_o != pend
    |=> counter_o == $past(counter_o) + 16'h0001; endproperty
  a_run: assert property (p_run) else $error("counter did not step");
  property p_frc; s_frc ##1 (s_frc and $stable({pf[0], output_initial_level_i, output_polarity_i}))
    |-> timer_out_o == (!(output_initial_level_i ^ pf[0]) ^ output_polarity_i); endproperty
  a_frc: assert property (p_frc) else $error("forced level wrong");
endmodule
`default_nettype wire
